// File: pkg/adms_pkg.sv
// Summary of operation
// - one-shot mode converts the selected input once per start, then stops
// - a conversion begins only when software writes the start bit to 1
// - one-shot completion clears the start bit by hardware
// - one-shot completion sets the interrupt request flag
// - repeat mode converts back to back until software clears start
// - repeat mode never sets the interrupt request flag
// - clearing start mid-conversion aborts it; result is then undefined
// - group 0 maps codes 0-7 to inputs 0-7; group 1 maps 4-7 to 8-11
// - writing the first control register mid-conversion leaves result undefined
// - sample-hold enable selects the shorter conversion sequence in both modes
// - results of both modes are read from the result register
// - repeat mode runs only at 8-bit resolution
// - without sample-hold a conversion takes 49 (8-bit) or 59 (10-bit) cycles
// - with sample-hold a conversion takes 28 (8-bit) or 33 (10-bit) cycles
package adms_pkg;
	// operating clock derived from the system clock
	localparam int CLK_MHZ = 100;
	localparam int AD_MHZ = 10;
	localparam int AD_DIV = CLK_MHZ / AD_MHZ;
	localparam logic [3:0] DIV_LAST = 4'(AD_DIV - 1);
	// register map, byte addresses
	localparam int AW = 12;
	localparam logic [AW-1:0] A_CF = 12'h000;
	localparam logic [AW-1:0] A_CS = 12'h004;
	localparam logic [AW-1:0] A_CT = 12'h008;
	localparam logic [AW-1:0] A_RES = 12'h00c;
	localparam logic [AW-1:0] A_ST = 12'h010;
	localparam logic [31:0] RST_VAL = 32'h0000_0000;
	// field positions
	localparam int CF_CH = 0;
	localparam int CH_W = 3;
	localparam int CF_REP = 3;
	localparam int CF_ST = 6;
	localparam int CS_TEN = 3;
	localparam int CS_GRP = 4;
	localparam int CS_REF = 5;
	localparam int CT_SH = 0;
	localparam int ST_FLAG = 0;
	localparam int ST_BUSY = 1;
	localparam int ST_BAD = 2;
	// conversion lengths in operating-clock cycles (49, 59, 28, 33)
	localparam int CNT_W = 6;
	localparam logic [CNT_W-1:0] CYC8 = 6'h31;
	localparam logic [CNT_W-1:0] CYC10 = 6'h3b;
	localparam logic [CNT_W-1:0] CYC8_SH = 6'h1c;
	localparam logic [CNT_W-1:0] CYC10_SH = 6'h21;
	localparam int RES_W = 10;
	localparam logic [3:0] NB8 = 4'h8;
	localparam logic [3:0] NB10 = 4'ha;

	typedef enum logic {CV_IDLE, CV_RUN} adms_state_t;

	function automatic logic [CNT_W-1:0] conv_cycles(input logic ten, input logic sh);
		if (sh) begin
			return ten ? CYC10_SH : CYC8_SH;
		end
		return ten ? CYC10 : CYC8;
	endfunction : conv_cycles

	// group 1 lands codes 100b..111b on inputs 8..11
	function automatic logic [3:0] chan_index(input logic grp, input logic [CH_W-1:0] code);
		return grp ? {2'b10, code[1:0]} : {1'b0, code};
	endfunction : chan_index

	function automatic logic chan_bad(input logic grp, input logic [CH_W-1:0] code);
		return grp & ~code[2];
	endfunction : chan_bad
endpackage : adms_pkg

// File: src/adms_conv.sv
`timescale 1ns/1ps
module adms_conv (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic tick,
	input wire logic run,
	input wire logic rep,
	input wire logic ten,
	input wire logic sh,
	input wire logic comp,
	output logic busy,
	output logic done,
	output logic [adms_pkg::RES_W-1:0] result,
	output logic [adms_pkg::RES_W-1:0] dac_code,
	output logic sampling
);
	import adms_pkg::*;

	adms_state_t st_q, st_d;
	logic [CNT_W-1:0] cnt_q, cnt_d, tot_q, tot_d;
	logic [3:0] nb_q, nb_d, ptr_q, ptr_d;
	logic [RES_W-1:0] sar_q, sar_d, res_q, res_d;
	logic ten_q, ten_d;
	logic first, last;

	// first trial just before the decision ticks, last decision at tot-1
	assign first = (cnt_q == tot_q - CNT_W'(nb_q) - 1'b1);
	assign last = (cnt_q == tot_q - 1'b1);
	assign busy = (st_q == CV_RUN);
	assign done = busy & run & tick & last;
	assign result = res_q;
	assign dac_code = ten_q ? sar_q : {sar_q[7:0], 2'b00};
	assign sampling = busy & (cnt_q < tot_q - CNT_W'(nb_q) - 1'b1);

	// sequencer next state
	always_comb begin
		st_d = st_q;
		cnt_d = cnt_q;
		tot_d = tot_q;
		nb_d = nb_q;
		ptr_d = ptr_q;
		sar_d = sar_q;
		res_d = res_q;
		ten_d = ten_q;
		if (!run) begin
			st_d = CV_IDLE;
		end else if (tick) begin
			case (st_q)
				CV_IDLE: begin
					st_d = CV_RUN;
					cnt_d = '0;
					tot_d = conv_cycles(ten, sh);
					nb_d = ten ? NB10 : NB8;
					ten_d = ten;
					sar_d = '0;
				end
				CV_RUN: begin
					cnt_d = cnt_q + 1'b1;
					if (first) begin
						ptr_d = nb_q - 1'b1;
						sar_d[nb_q - 1'b1] = 1'b1;
					end else if (cnt_q > tot_q - CNT_W'(nb_q) - 1'b1) begin
						// keep the trial bit when the input sits above it
						sar_d[ptr_q] = comp;
						if (ptr_q != 4'h0) begin
							sar_d[ptr_q - 1'b1] = 1'b1;
							ptr_d = ptr_q - 1'b1;
						end
					end
					if (last) begin
						res_d = sar_d;
						cnt_d = '0;
						sar_d = '0;
						st_d = rep ? CV_RUN : CV_IDLE;
					end
				end
				default: st_d = CV_IDLE;
			endcase
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			st_q <= CV_IDLE;
			cnt_q <= '0;
			tot_q <= CYC8;
			nb_q <= NB8;
			ptr_q <= '0;
			sar_q <= '0;
			res_q <= '0;
			ten_q <= 1'b0;
		end else begin
			st_q <= st_d;
			cnt_q <= cnt_d;
			tot_q <= tot_d;
			nb_q <= nb_d;
			ptr_q <= ptr_d;
			sar_q <= sar_d;
			res_q <= res_d;
			ten_q <= ten_d;
		end
	end
endmodule : adms_conv

// File: src/adms_top.sv
`timescale 1ns/1ps
module adms_top (
	input wire logic clock,
	input wire logic arst_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [adms_pkg::AW-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic comp_hi,
	output logic [3:0] analog_select,
	output logic [adms_pkg::RES_W-1:0] dac_code,
	output logic sample_hold,
	output logic reference_connect,
	output logic interrupt_request_flag
);
	import adms_pkg::*;

	logic rs1_q, rst_n;
	logic cs1_q, cs2_q;
	logic [3:0] div_q, div_d;
	logic tick;
	logic wr, rd_setup, mapped;
	logic [CH_W-1:0] chan_q, chan_d;
	logic rep_q, rep_d;
	logic start_q, start_d;
	logic ten_q, ten_d;
	logic grp_q, grp_d;
	logic ref_q, ref_d;
	logic sh_q, sh_d;
	logic flag_q, flag_d;
	logic [3:0] sel_q, sel_d;
	logic [31:0] rdata_q, rdata_d;
	logic busy, done, ten_eff;
	logic [RES_W-1:0] result;

	// reset release through two flops; assertion stays asynchronous
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			rs1_q <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rs1_q <= 1'b1;
			rst_n <= rs1_q;
		end
	end

	// comparator pin comes from the analog side, so synchronise it
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			cs1_q <= 1'b0;
			cs2_q <= 1'b0;
		end else begin
			cs1_q <= comp_hi;
			cs2_q <= cs1_q;
		end
	end

	// operating clock enable, fixed at the 10 MHz ceiling
	assign tick = (div_q == DIV_LAST);
	always_comb begin
		div_d = tick ? 4'h0 : div_q + 1'b1;
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			div_q <= '0;
		end else begin
			div_q <= div_d;
		end
	end

	// apb decode: zero wait states, error on unmapped words
	assign mapped = (paddr == A_CF)
		| (paddr == A_CS)
		| (paddr == A_CT)
		| (paddr == A_RES)
		| (paddr == A_ST);
	assign wr = psel & penable & pwrite & mapped;
	assign rd_setup = psel & ~penable & ~pwrite;
	assign pready = 1'b1;
	assign pslverr = psel & penable & ~mapped;
	assign prdata = rdata_q;

	// repeat mode is forced to 8-bit resolution
	assign ten_eff = ten_q & ~rep_q;

	// control register next values
	always_comb begin
		chan_d = chan_q;
		rep_d = rep_q;
		start_d = start_q;
		ten_d = ten_q;
		grp_d = grp_q;
		ref_d = ref_q;
		sh_d = sh_q;
		flag_d = flag_q;
		if (wr && paddr == A_CF) begin
			// no guard while converting; such writes spoil the result
			chan_d = pwdata[CF_CH +: CH_W];
			rep_d = pwdata[CF_REP];
			start_d = pwdata[CF_ST];
		end
		if (wr && paddr == A_CS) begin
			ten_d = pwdata[CS_TEN];
			grp_d = pwdata[CS_GRP];
			ref_d = pwdata[CS_REF];
		end
		if (wr && paddr == A_CT) begin
			sh_d = pwdata[CT_SH];
		end
		if (wr && paddr == A_ST && pwdata[ST_FLAG]) begin
			flag_d = 1'b0;
		end
		// hardware completion beats a same-cycle software write
		if (done && !rep_q) begin
			start_d = 1'b0;
			flag_d = 1'b1;
		end
		sel_d = chan_index(grp_d, chan_d);
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			chan_q <= '0;
			rep_q <= 1'b0;
			start_q <= 1'b0;
			ten_q <= 1'b0;
			grp_q <= 1'b0;
			ref_q <= 1'b0;
			sh_q <= 1'b0;
			flag_q <= 1'b0;
			sel_q <= '0;
		end else begin
			chan_q <= chan_d;
			rep_q <= rep_d;
			start_q <= start_d;
			ten_q <= ten_d;
			grp_q <= grp_d;
			ref_q <= ref_d;
			sh_q <= sh_d;
			flag_q <= flag_d;
			sel_q <= sel_d;
		end
	end

	// read data captured in the setup phase, shown in the access phase
	always_comb begin
		rdata_d = rdata_q;
		if (rd_setup) begin
			rdata_d = RST_VAL;
			case (paddr)
				A_CF: begin
					rdata_d[CF_CH +: CH_W] = chan_q;
					rdata_d[CF_REP] = rep_q;
					rdata_d[CF_ST] = start_q;
				end
				A_CS: begin
					rdata_d[CS_TEN] = ten_q;
					rdata_d[CS_GRP] = grp_q;
					rdata_d[CS_REF] = ref_q;
				end
				A_CT: rdata_d[CT_SH] = sh_q;
				A_RES: rdata_d[RES_W-1:0] = result;
				A_ST: begin
					rdata_d[ST_FLAG] = flag_q;
					rdata_d[ST_BUSY] = busy;
					rdata_d[ST_BAD] = chan_bad(grp_q, chan_q);
				end
				default: rdata_d = RST_VAL;
			endcase
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			rdata_q <= RST_VAL;
		end else begin
			rdata_q <= rdata_d;
		end
	end

	// conversion engine runs while the start bit stands
	adms_conv u_conv (
		.clock(clock),
		.rst_n(rst_n),
		.tick(tick),
		.run(start_q),
		.rep(rep_q),
		.ten(ten_eff),
		.sh(sh_q),
		.comp(cs2_q),
		.busy(busy),
		.done(done),
		.result(result),
		.dac_code(dac_code),
		.sampling(sample_hold)
	);

	assign analog_select = sel_q;
	assign reference_connect = ref_q;
	assign interrupt_request_flag = flag_q;

	// helper: operating-clock cycles spent in the current conversion
	logic [CNT_W-1:0] tc_q;
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			tc_q <= '0;
		end else if (done || !busy) begin
			tc_q <= '0;
		end else if (tick) begin
			tc_q <= tc_q + 1'b1;
		end
	end

	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!rst_n);

	sequence oneshot_end;
		done && !rep_q;
	endsequence

	sequence flag_untouched;
		!(wr && paddr == A_ST && pwdata[ST_FLAG]);
	endsequence

	// one-shot completion stops the engine, drops start and raises the flag
	oneshot_stop_a: assert property (oneshot_end |=> !start_q ##1 !busy)
		else $error("one-shot did not stop after completion");
	start_clear_a: assert property (oneshot_end |=> !start_q)
		else $error("start bit not cleared on one-shot completion");
	flag_set_a: assert property (oneshot_end |=> flag_q && interrupt_request_flag)
		else $error("request flag not set on one-shot completion");

	// repeat mode chains conversions and never touches the flag
	repeat_noflag_a: assert property ((done && rep_q && !flag_q) ##0 flag_untouched |=> !flag_q)
		else $error("repeat mode raised the request flag");
	repeat_chain_a: assert property (done && rep_q && start_q |=> busy [*3])
		else $error("repeat mode did not continue back to back");
	repeat_start_a: assert property (done && rep_q && !(wr && paddr == A_CF) |=> start_q)
		else $error("repeat mode dropped the start bit");
	repeat_res_a: assert property (busy && rep_q |-> !u_conv.ten_q)
		else $error("repeat mode ran at 10-bit resolution");

	// software alone raises start; clearing it stops the engine at once
	abort_stop_a: assert property (busy && !start_q |=> !busy)
		else $error("conversion not aborted when start cleared");
	start_cause_a: assert property ($rose(busy) |-> $past(start_q))
		else $error("conversion began without the start bit");
	start_low_a: assert property (!start_q && !(wr && paddr == A_CF) |=> !start_q)
		else $error("start bit rose without a software write");
	start_hold_a: assert property (start_q && !done && !(wr && paddr == A_CF) |=> start_q)
		else $error("start bit fell on its own");
	busy_tick_a: assert property ($rose(busy) |-> $past(tick))
		else $error("conversion began off the operating clock");

	// request flag: only one-shot completion sets it, only software clears it
	flag_cause_a: assert property ($rose(flag_q) |-> $past(done && !rep_q))
		else $error("request flag rose without one-shot completion");
	flag_hold_a: assert property (flag_q ##0 flag_untouched |=> flag_q)
		else $error("request flag dropped without a clear");
	flag_clear_a: assert property (wr && paddr == A_ST && pwdata[ST_FLAG] && !(done && !rep_q) |=> !flag_q)
		else $error("request flag not cleared by software");

	// select is registered together with its fields, so it matches them in the same cycle
	chan_map_a: assert property (grp_q && chan_q[2] |-> analog_select[3] && analog_select[1:0] == chan_q[1:0])
		else $error("group one channel mapped wrongly");
	chan_low_a: assert property (!grp_q |-> analog_select == {1'b0, chan_q})
		else $error("group zero channel mapped wrongly");

	// enable pulse spacing and conversion length for each setting
	tick_gap_a: assert property (tick |=> !tick)
		else $error("operating clock enable ran too fast");
	div_range_a: assert property (div_q <= DIV_LAST)
		else $error("divider left its range");
	conv_load_a: assert property ($rose(busy) |-> u_conv.tot_q == conv_cycles($past(ten_eff), $past(sh_q)))
		else $error("conversion loaded the wrong cycle count");
	conv_len_a: assert property (done |-> tc_q == conv_cycles(ten_eff, sh_q) - 1'b1)
		else $error("conversion length differs from the cycle count");
	cnt_range_a: assert property (busy |-> u_conv.cnt_q < u_conv.tot_q)
		else $error("conversion counter overran");
	sample_busy_a: assert property (sample_hold |-> busy)
		else $error("sampling outside a conversion");

	// result moves only at completion; an aborted conversion leaves it alone
	result_hold_a: assert property (!done |=> $stable(result))
		else $error("result changed without a completion");
	narrow_res_a: assert property (done && !u_conv.ten_q |=> (result >> NB8) == '0)
		else $error("8-bit result has high bits set");
	result_rd_a: assert property (rd_setup && paddr == A_RES |=> prdata[RES_W-1:0] == $past(result))
		else $error("result register read returned wrong data");

	// register reads show the state captured at the setup edge
	rd_ctrl_a: assert property (rd_setup && paddr == A_CF |=> prdata[CF_ST] == $past(start_q))
		else $error("start bit read back wrongly");
	rd_flag_a: assert property (rd_setup && paddr == A_ST |=> prdata[ST_FLAG] == $past(flag_q))
		else $error("request flag read back wrongly");
	rd_unmapped_a: assert property (rd_setup && !mapped |=> prdata == RST_VAL)
		else $error("unmapped read returned data");
	err_access_a: assert property (pslverr |-> psel && penable)
		else $error("slave error outside an access phase");
endmodule : adms_top

// File: dv/adms_afe_model.sv
`timescale 1ns/1ps
module adms_afe_model (
	input wire logic [3:0] analog_select,
	input wire logic [adms_pkg::RES_W-1:0] dac_code,
	input wire logic sample_hold,
	output logic comp_hi
);
	import adms_pkg::*;
	// each input sits at a fixed, spread-out level so every result is predictable
	function automatic logic [RES_W-1:0] level(input logic [3:0] idx);
		return RES_W'(idx * 83 + 37);
	endfunction : level
	// comparator: high while the input is at or above the trial code; held low while
	// sampling so a decision taken too early shows up as a wrong result
	always_comb begin
		comp_hi = !sample_hold && (level(analog_select) >= dac_code);
	end
endmodule : adms_afe_model

// File: dv/adc_mode_sequencer_tb.sv
`timescale 1ns/1ps
module adc_mode_sequencer_tb;
	import adms_pkg::*;
	logic clock = 0;
	logic arst_n = 0;
	logic psel = 0;
	logic penable = 0;
	logic pwrite = 0;
	logic [AW-1:0] paddr = '0;
	logic [31:0] pwdata = '0;
	logic [31:0] prdata, rd;
	logic pready, pslverr, err, comp_hi, ref_c, irq, sh_o, grp, ten, sh;
	logic [3:0] sel, idx;
	logic [RES_W-1:0] dac;
	logic [2:0] code;
	int miscompares = 0;
	int n_tests = 0;
	int n, cnt, hcnt;

	adms_top dut_u (.clock(clock), .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.comp_hi(comp_hi), .analog_select(sel), .dac_code(dac), .sample_hold(sh_o),
		.reference_connect(ref_c), .interrupt_request_flag(irq));
	adms_afe_model afe_u (.analog_select(sel), .dac_code(dac), .sample_hold(sh_o), .comp_hi(comp_hi));

	initial begin
		forever #5 clock = ~clock;
	end

	task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			miscompares++;
			$display("ERROR %s expected %h seen %h", name, exp, seen);
		end
	endtask : chk

	// one apb transfer; held until pready is seen high, only the watchdog ends a hung wait
	task apb(input logic w, input logic [AW-1:0] a, input logic [31:0] d);
		@(posedge clock);
		psel <= 1;
		penable <= 0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1;
		do begin
			@(posedge clock);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 0;
		penable <= 0;
	endtask : apb

	function automatic logic [31:0] exp_res(input logic [3:0] i, input logic t);
		logic [RES_W-1:0] v;
		v = RES_W'(i * 83 + 37);
		return t ? 32'(v) : 32'(v[9:2]);
	endfunction : exp_res

	task complete_run();
		$display("tests %0d miscompares %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : complete_run

	initial begin
		repeat (30000) @(posedge clock);
		miscompares++;
		complete_run();
	end

	initial begin
		void'($urandom(59));
		repeat (2) @(posedge clock);
		arst_n <= 1;
		repeat (3) @(posedge clock);
		apb(0, A_ST, 0);
		chk("status_rst", rd, RST_VAL);
		apb(1, 12'h020, 32'hffff_ffff);
		chk("slverr", 32'(err), 1);
		// connect the reference, then let it settle before any start
		apb(1, A_CS, 32'h0000_0020);
		repeat (100) @(posedge clock);
		chk("ref", 32'(ref_c), 1);
		// one-shot over all resolution and sample-hold combinations, random channels
		for (int i = 0; i < 8; i++) begin
			ten = i[0];
			sh = i[1];
			grp = 1'($urandom);
			code = 3'($urandom);
			if (grp) begin
				code[2] = 1'b1;
			end
			idx = grp ? {2'b10, code[1:0]} : {1'b0, code};
			apb(1, A_CS, {26'h0, 1'b1, grp, ten, 3'h0});
			apb(1, A_CT, {31'h0, sh});
			apb(1, A_CF, {25'h0, 1'b1, 3'h0, code});
			cnt = 0;
			hcnt = 0;
			while (irq !== 1'b1 && cnt < 2000) begin
				@(posedge clock);
				cnt++;
				if (sh_o === 1'b1) begin
					hcnt++;
				end
			end
			n = sh ? (ten ? 33 : 28) : (ten ? 59 : 49);
			chk("cycles", 32'(cnt >= n * 10 && cnt <= n * 10 + 15), 1);
			// sampling spans every tick before the first trial bit
			chk("sample_len", 32'(hcnt), 32'((n - (ten ? 11 : 9)) * 10));
			chk("flag", 32'(irq), 1);
			chk("select", 32'(sel), 32'(idx));
			apb(0, A_CF, 0);
			chk("start_clr", 32'(rd[CF_ST]), 0);
			apb(0, A_RES, 0);
			chk("result", rd, exp_res(idx, ten));
			apb(1, A_ST, 1);
			apb(0, A_ST, 0);
			chk("flag_clr", 32'(rd[ST_FLAG]), 0);
		end
		// repeat mode with 10-bit requested: must still run 8-bit, no flag
		apb(1, A_CS, 32'h0000_0028);
		apb(1, A_CT, 0);
		apb(1, A_CF, 32'h0000_004d);
		repeat (1500) @(posedge clock);
		chk("rep_noflag", 32'(irq), 0);
		apb(0, A_CF, 0);
		chk("rep_run", 32'(rd[CF_ST]), 1);
		apb(0, A_RES, 0);
		chk("rep_result", rd, exp_res(4'h5, 1'b0));
		apb(1, A_CF, 32'h0000_000d);
		apb(0, A_ST, 0);
		chk("rep_stop", 32'(rd[ST_BUSY]), 0);
		// abort a one-shot about a third of the way through
		apb(1, A_CF, 32'h0000_0002);
		apb(1, A_CF, 32'h0000_0042);
		repeat (200) @(posedge clock);
		apb(1, A_CF, 32'h0000_0002);
		apb(0, A_ST, 0);
		chk("abort_busy", 32'(rd[ST_BUSY]), 0);
		repeat (600) @(posedge clock);
		chk("abort_noflag", 32'(irq), 0);
		// group 1 with a low code is forbidden and flagged
		apb(1, A_CS, 32'h0000_0030);
		apb(0, A_ST, 0);
		chk("forbidden", 32'(rd[ST_BAD]), 1);
		complete_run();
	end
endmodule : adc_mode_sequencer_tb
